// ===== inc/pin_override_consts.vh
// Summary of operation
// RULE_01 - clock fuse puts divided clock on b1
// RULE_02 - divided clock also drives b1 during reset
// RULE_03 - b0 direction bit picks usart clock direction
// RULE_04 - usart clock on b0 only in sync mode
// RULE_05 - miso carries master input or slave output
// RULE_06 - mosi carries master output or slave input
// RULE_07 - spi role overrides b7..b4, b4 compare output
// RULE_08 - b3 compare value, b1 clock override
// RULE_09 - port b input enable by pin-change masks
// RULE_10 - jtag forces pull-up, direction on c5..c2
// RULE_11 - timer oscillator overrides c7 and c6
// RULE_12 - port c input enable by pin-change masks
// RULE_13 - b1 feeds timer1 count, b0 timer0 count
// RULE_14 - override enable selects override value
// RULE_15 - global pull-up disable blocks every pull-up
`ifndef PIN_OVERRIDE_CONSTS_VH
`define PIN_OVERRIDE_CONSTS_VH

// register byte offsets
`define OFS_PORTB_VALUE 8'h00
`define OFS_PORTB_DIR   8'h04
`define OFS_PORTC_VALUE 8'h08
`define OFS_PORTC_DIR   8'h0C
`define OFS_PCMASK_B    8'h10
`define OFS_PCMASK_C    8'h14
`define OFS_CONTROL     8'h18
`define OFS_PIN_STATUS  8'h1C

// control register fields
`define CTRL_PULLUP_DIS 0
`define CTRL_PCIE_B     1
`define CTRL_PCIE_C     2
`define CTRL_EXT_IRQ2_INPUT_EN    3
`define CTRL_WIDTH      4

// reset values
`define RST_BYTE        8'h00
`define RST_CTRL        4'h0
`define RST_WORD        32'h0000_0000

// answer codes
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ===== hdl/pin_apply.v
`timescale 1ns/10ps
`include "pin_override_consts.vh"

// resolves the override pairs of one 8-bit port against its port registers
module pin_apply (
  // port register settings
  input  wire [7:0] port_value,
  input  wire [7:0] port_direction,
  input  wire       global_pullup_disable,
  // override pairs
  input  wire [7:0] pullup_override_enable,
  input  wire [7:0] pullup_override_value,
  input  wire [7:0] direction_override_enable,
  input  wire [7:0] direction_override_value,
  input  wire [7:0] port_value_override_enable,
  input  wire [7:0] port_value_override_value,
  input  wire [7:0] input_enable_override_enable,
  input  wire [7:0] input_enable_override_value,
  // resolved pin controls
  output wire [7:0] pull_on,
  output wire [7:0] direction,
  output wire [7:0] value,
  output wire [7:0] input_enable
);
  wire [7:0] pull_allowed = {8{~global_pullup_disable}};
  wire [7:0] pu_norm = port_value & ~port_direction;

  // each field takes its override only while the matching enable is set
  assign pull_on = ((pullup_override_enable & pullup_override_value) |
                    (~pullup_override_enable & pu_norm)) & pull_allowed; // see RULE_14 see RULE_15
  assign direction = (direction_override_enable & direction_override_value) |
                     (~direction_override_enable & port_direction); // see RULE_14
  assign value = (port_value_override_enable & port_value_override_value) |
                 (~port_value_override_enable & port_value); // see RULE_14
  // without an override the digital input stays on
  assign input_enable = (input_enable_override_enable & input_enable_override_value) |
                        ~input_enable_override_enable; // see RULE_14
endmodule // pin_apply

// ===== hdl/axil_regs.v
`timescale 1ns/10ps
`include "pin_override_consts.vh"

// axi4-lite register file: port settings, pin-change masks, control, pin status
module axil_regs (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // write channels
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // read channels
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // register contents and status
  output reg  [7:0]  portb_value,
  output reg  [7:0]  portb_direction,
  output reg  [7:0]  portc_value,
  output reg  [7:0]  portc_direction,
  output reg  [7:0]  pcmask_b,
  output reg  [7:0]  pcmask_c,
  output reg  [`CTRL_WIDTH-1:0] control,
  input  wire [15:0] pin_status
);
  reg  [7:0]  aw_addr;
  reg         aw_held;
  reg  [7:0]  w_data;
  reg         w_lane0;
  reg         w_held;
  wire        aw_take = s_axi_awvalid & s_axi_awready;
  wire        w_take  = s_axi_wvalid & s_axi_wready;
  wire        do_write = aw_held & w_held & ~s_axi_bvalid;

  // writable registers are at most byte wide, so only lane 0 carries data
  function [7:0] merge;
    input [7:0] old;
    input [7:0] data;
    input       lane;
    begin
      merge = lane ? data : old;
    end
  endfunction

  // address and data are latched independently, in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= `RST_BYTE;
      w_data        <= `RST_BYTE;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~aw_take & ~s_axi_bvalid & ~do_write;
      s_axi_wready  <= ~w_held & ~w_take & ~s_axi_bvalid & ~do_write;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held  <= 1'b1;
        w_data  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr <= `OFS_CONTROL && aw_addr[1:0] == 2'b00) ?
                        `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register storage; status word is read only
  always @(posedge aclk) begin
    if (!aresetn) begin
      portb_value     <= `RST_BYTE;
      portb_direction <= `RST_BYTE;
      portc_value     <= `RST_BYTE;
      portc_direction <= `RST_BYTE;
      pcmask_b        <= `RST_BYTE;
      pcmask_c        <= `RST_BYTE;
      control         <= `RST_CTRL;
    end else if (do_write) begin
      case (aw_addr)
        `OFS_PORTB_VALUE: portb_value     <= merge(portb_value, w_data, w_lane0);
        `OFS_PORTB_DIR:   portb_direction <= merge(portb_direction, w_data, w_lane0);
        `OFS_PORTC_VALUE: portc_value     <= merge(portc_value, w_data, w_lane0);
        `OFS_PORTC_DIR:   portc_direction <= merge(portc_direction, w_data, w_lane0);
        `OFS_PCMASK_B:    pcmask_b        <= merge(pcmask_b, w_data, w_lane0);
        `OFS_PCMASK_C:    pcmask_c        <= merge(pcmask_c, w_data, w_lane0);
        `OFS_CONTROL: begin
          if (w_lane0) begin
            control <= w_data[`CTRL_WIDTH-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // reads answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `RST_WORD;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `OFS_PORTB_VALUE: s_axi_rdata <= {24'h00_0000, portb_value};
          `OFS_PORTB_DIR:   s_axi_rdata <= {24'h00_0000, portb_direction};
          `OFS_PORTC_VALUE: s_axi_rdata <= {24'h00_0000, portc_value};
          `OFS_PORTC_DIR:   s_axi_rdata <= {24'h00_0000, portc_direction};
          `OFS_PCMASK_B:    s_axi_rdata <= {24'h00_0000, pcmask_b};
          `OFS_PCMASK_C:    s_axi_rdata <= {24'h00_0000, pcmask_c};
          `OFS_CONTROL:     s_axi_rdata <= {28'h000_0000, control};
          `OFS_PIN_STATUS:  s_axi_rdata <= {16'h0000, pin_status};
          default: begin
            s_axi_rdata <= `RST_WORD;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // axil_regs

// ===== hdl/port_bc_override.v
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "pin_override_consts.vh"

// alternate-function override for port b and the upper port c pins
module port_bc_override (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite register bus
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // clock and fuse
  input  wire        clock_out_fuse,
  input  wire        divided_sysclk_out,
  // serial peripheral
  input  wire        spi_enable,
  input  wire        spi_master_select,
  input  wire        spi_sck_out,
  input  wire        spi_slave_data_out,
  input  wire        spi_master_data_out,
  output reg         spi_sck_in,
  output reg         spi_master_data_in,
  output reg         spi_slave_data_in,
  output reg         spi_slave_select_n,
  // timers
  input  wire        timer0_compare_a_out,
  input  wire        timer0_compare_a_enable,
  input  wire        timer0_compare_b_out,
  input  wire        timer0_compare_b_enable,
  output reg         timer0_count_input,
  output reg         timer1_count_input,
  input  wire        async_timer2_select,
  input  wire        ext_clock_select,
  // usart0
  input  wire        usart0_sync_mode,
  input  wire        usart0_clock_out,
  output reg         usart0_sync_clock,
  // jtag
  input  wire        jtag_port_enable,
  input  wire        tap_instr_shift_state,
  input  wire        tap_data_shift_state,
  input  wire        tap_data_out,
  output reg         tap_data_in,
  output reg         tap_mode_in,
  output reg         tap_clock_in,
  // interrupt inputs
  output reg         ext_irq2_input,
  output reg  [7:0]  pin_change_b,
  output reg  [7:0]  pin_change_c,
  // port b pins
  input  wire [7:0]  portb_pin_in,
  output reg  [7:0]  portb_pin_out,
  output reg  [7:0]  portb_pin_oe,
  output reg  [7:0]  portb_pullup,
  // port c pins
  input  wire [7:0]  portc_pin_in,
  output reg  [7:0]  portc_pin_out,
  output reg  [7:0]  portc_pin_oe,
  output reg  [7:0]  portc_pullup
);

  //////////////////////////////////////////////////////////////////////////////
  // register file
  wire [7:0] portb_value;
  wire [7:0] portb_direction;
  wire [7:0] portc_value;
  wire [7:0] portc_direction;
  wire [7:0] pcmask_b;
  wire [7:0] pcmask_c;
  wire [`CTRL_WIDTH-1:0] control;
  reg  [7:0] pb_meta;
  reg  [7:0] pb_sync;
  reg  [7:0] pc_meta;
  reg  [7:0] pc_sync;

  axil_regs u_regs (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .s_axi_awaddr    (s_axi_awaddr),
    .s_axi_awvalid   (s_axi_awvalid),
    .s_axi_awready   (s_axi_awready),
    .s_axi_wdata     (s_axi_wdata),
    .s_axi_wstrb     (s_axi_wstrb),
    .s_axi_wvalid    (s_axi_wvalid),
    .s_axi_wready    (s_axi_wready),
    .s_axi_bresp     (s_axi_bresp),
    .s_axi_bvalid    (s_axi_bvalid),
    .s_axi_bready    (s_axi_bready),
    .s_axi_araddr    (s_axi_araddr),
    .s_axi_arvalid   (s_axi_arvalid),
    .s_axi_arready   (s_axi_arready),
    .s_axi_rdata     (s_axi_rdata),
    .s_axi_rresp     (s_axi_rresp),
    .s_axi_rvalid    (s_axi_rvalid),
    .s_axi_rready    (s_axi_rready),
    .portb_value     (portb_value),
    .portb_direction (portb_direction),
    .portc_value     (portc_value),
    .portc_direction (portc_direction),
    .pcmask_b        (pcmask_b),
    .pcmask_c        (pcmask_c),
    .control         (control),
    .pin_status      ({pc_sync, pb_sync})
  );

  wire global_pullup_disable     = control[`CTRL_PULLUP_DIS];
  wire pin_change_group_b_enable = control[`CTRL_PCIE_B];
  wire pin_change_group_c_enable = control[`CTRL_PCIE_C];
  wire ext_irq2_enable           = control[`CTRL_EXT_IRQ2_INPUT_EN];

  //////////////////////////////////////////////////////////////////////////////
  // port b override terms
  wire spi_slave  = spi_enable & ~spi_master_select;
  wire spi_master = spi_enable & spi_master_select;
  wire xck_active = usart0_sync_mode;
  wire [7:0] pc_b = pcmask_b & {8{pin_change_group_b_enable}};
  reg  [7:0] b_pu_en;
  reg  [7:0] b_dd_en;
  reg  [7:0] b_dd_val;
  reg  [7:0] b_pv_en;
  reg  [7:0] b_pv_val;
  reg  [7:0] b_ie_en;

  // spi forces inputs by role; the other pins go to timers, clocks and the b2 interrupt
  always @* begin
    b_pu_en  = {spi_slave, spi_master, spi_slave, spi_slave, 4'h0}; // see RULE_07
    b_dd_en  = b_pu_en;
    b_dd_val = 8'h00; // see RULE_07
    b_pv_en  = {spi_master, spi_slave, spi_master,
                timer0_compare_b_enable, timer0_compare_a_enable,
                1'b0, clock_out_fuse, 1'b0}; // see RULE_07 see RULE_08
    b_pv_val = {spi_sck_out, spi_slave_data_out, spi_master_data_out,
                timer0_compare_b_out, timer0_compare_a_out,
                1'b0, divided_sysclk_out, 1'b0}; // see RULE_05 see RULE_06
    // the fuse beats any port setting on bit 1
    b_dd_en[1]  = clock_out_fuse; // see RULE_01 see RULE_08
    b_dd_val[1] = clock_out_fuse;
    // sync usart clock drives bit 0 only when its direction bit says output
    b_pv_en[0]  = xck_active & portb_direction[0]; // see RULE_03 see RULE_04
    b_pv_val[0] = usart0_clock_out;
    b_ie_en     = pc_b;
    b_ie_en[2]  = pc_b[2] | ext_irq2_enable; // see RULE_09
  end

  wire [7:0] b_pull;
  wire [7:0] b_dir;
  wire [7:0] b_val;
  wire [7:0] b_die;

  pin_apply u_port_b (
    .port_value                   (portb_value),
    .port_direction               (portb_direction),
    .global_pullup_disable        (global_pullup_disable),
    .pullup_override_enable       (b_pu_en),
    .pullup_override_value        (portb_value), // see RULE_15
    .direction_override_enable    (b_dd_en),
    .direction_override_value     (b_dd_val),
    .port_value_override_enable   (b_pv_en),
    .port_value_override_value    (b_pv_val),
    .input_enable_override_enable (b_ie_en),
    .input_enable_override_value  (8'hFF), // see RULE_09
    .pull_on                      (b_pull),
    .direction                    (b_dir),
    .value                        (b_val),
    .input_enable                 (b_die)
  );

  //////////////////////////////////////////////////////////////////////////////
  // port c override terms
  wire osc_c7 = async_timer2_select & ext_clock_select;
  wire [7:0] pc_c = pcmask_c & {8{pin_change_group_c_enable}};
  reg  [7:0] c_pu_en;
  reg  [7:0] c_dd_val;
  reg  [7:0] c_pv_en;
  reg  [7:0] c_pv_val;
  reg  [7:0] c_ie_en;
  reg  [7:0] c_ie_val;

  // two-wire pins c1..c0 are not handled here and keep plain port behaviour
  always @* begin
    c_pu_en = {osc_c7, async_timer2_select, {4{jtag_port_enable}}, 2'b00}; // see RULE_10
    c_dd_val = 8'h00; // see RULE_11
    c_dd_val[4] = tap_instr_shift_state | tap_data_shift_state; // see RULE_10
    c_pv_en = {3'b000, jtag_port_enable, 4'h0};
    c_pv_val = {3'b000, tap_data_out, 4'h0};
    c_ie_en = c_pu_en | pc_c; // see RULE_11 see RULE_12
    // a masked-in pin-change source always keeps its input alive
    c_ie_val = {async_timer2_select, ext_clock_select | async_timer2_select,
                {4{jtag_port_enable}}, 2'b11} | pc_c; // see RULE_12
  end

  // pull-up value: 1 under jtag, 0 under oscillator, port bit elsewhere
  wire [7:0] c_pu_val = {2'b00, 4'hF, portc_value[1:0]}; // see RULE_10 see RULE_11

  wire [7:0] c_pull;
  wire [7:0] c_dir;
  wire [7:0] c_val;
  wire [7:0] c_die;

  pin_apply u_port_c (
    .port_value                   (portc_value),
    .port_direction               (portc_direction),
    .global_pullup_disable        (global_pullup_disable),
    .pullup_override_enable       (c_pu_en),
    .pullup_override_value        (c_pu_val),
    .direction_override_enable    (c_pu_en),
    .direction_override_value     (c_dd_val),
    .port_value_override_enable   (c_pv_en),
    .port_value_override_value    (c_pv_val),
    .input_enable_override_enable (c_ie_en),
    .input_enable_override_value  (c_ie_val),
    .pull_on                      (c_pull),
    .direction                    (c_dir),
    .value                        (c_val),
    .input_enable                 (c_die)
  );

  //////////////////////////////////////////////////////////////////////////////
  // pin drive registers
  // reset keeps the divided clock on bit 1 when the fuse asks for it
  always @(posedge aclk) begin
    if (!aresetn) begin
      portb_pin_out <= {6'h00, clock_out_fuse & divided_sysclk_out, 1'b0}; // see RULE_02
      portb_pin_oe  <= {6'h00, clock_out_fuse, 1'b0}; // see RULE_02
      portb_pullup  <= `RST_BYTE;
      portc_pin_out <= `RST_BYTE;
      portc_pin_oe  <= `RST_BYTE;
      portc_pullup  <= `RST_BYTE;
    end else begin
      portb_pin_out <= b_val;
      portb_pin_oe  <= b_dir;
      portb_pullup  <= b_pull & ~b_dir;
      portc_pin_out <= c_val;
      portc_pin_oe  <= c_dir;
      portc_pullup  <= c_pull & ~c_dir;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin inputs: two flops before anything looks at them
  always @(posedge aclk) begin
    if (!aresetn) begin
      pb_meta <= `RST_BYTE;
      pb_sync <= `RST_BYTE;
      pc_meta <= `RST_BYTE;
      pc_sync <= `RST_BYTE;
    end else begin
      pb_meta <= portb_pin_in;
      pb_sync <= pb_meta;
      pc_meta <= portc_pin_in;
      pc_sync <= pc_meta;
    end
  end

  wire [7:0] b_in = pb_sync & b_die;
  wire [7:0] c_in = pc_sync & c_die;

  // gated inputs to the peripherals; slave select idles high
  always @(posedge aclk) begin
    if (!aresetn) begin
      spi_sck_in         <= 1'b0;
      spi_master_data_in <= 1'b0;
      spi_slave_data_in  <= 1'b0;
      spi_slave_select_n <= 1'b1;
      ext_irq2_input     <= 1'b0;
      timer1_count_input <= 1'b0;
      timer0_count_input <= 1'b0;
      usart0_sync_clock  <= 1'b0;
      tap_data_in        <= 1'b0;
      tap_mode_in        <= 1'b0;
      tap_clock_in       <= 1'b0;
      pin_change_b       <= `RST_BYTE;
      pin_change_c       <= `RST_BYTE;
    end else begin
      spi_sck_in         <= b_in[7];
      spi_master_data_in <= b_in[6]; // see RULE_05
      spi_slave_data_in  <= b_in[5]; // see RULE_06
      spi_slave_select_n <= b_in[4] | ~spi_slave;
      ext_irq2_input     <= b_in[2];
      timer1_count_input <= b_in[1]; // see RULE_13
      timer0_count_input <= b_in[0]; // see RULE_13
      // an input clock only while in sync mode with bit 0 as input
      usart0_sync_clock  <= b_in[0] & xck_active & ~portb_direction[0]; // see RULE_03 see RULE_04
      tap_data_in        <= c_in[5] & jtag_port_enable;
      tap_mode_in        <= c_in[3] & jtag_port_enable;
      tap_clock_in       <= c_in[2] & jtag_port_enable;
      pin_change_b       <= b_in & pcmask_b;
      pin_change_c       <= c_in & pcmask_c; // see RULE_12
    end
  end
endmodule // port_bc_override

// ===== test/pin_world.sv
`timescale 1ns/10ps
module pin_world (
  // pin controls from the block
  input  wire [7:0] pin_out,
  input  wire [7:0] pin_oe,
  // board side
  input  wire [7:0] ext,
  output wire [7:0] pin_in
);
  // resolved pin level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule // pin_world

// ===== test/port_bc_monitor.sv
`timescale 1ns/10ps
// pin controls follow the peripheral state sampled one edge earlier
module port_bc_monitor (
  // clock and reset
  input wire       aclk, aresetn,
  // peripheral state
  input wire       clock_out_fuse, divided_sysclk_out,
  input wire       spi_enable, spi_master_select, spi_master_data_out,
  input wire       timer0_compare_a_out, timer0_compare_a_enable,
  input wire       jtag_port_enable, tap_instr_shift_state, tap_data_shift_state, tap_data_out,
  // pin controls
  input wire [7:0] portb_pin_out, portb_pin_oe, portb_pullup,
  input wire [7:0] portc_pin_out, portc_pin_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // skip the edge after release, where outputs still carry reset values
  sequence s_run; $past(aresetn); endsequence
  sequence s_master; s_run ##0 $past(spi_enable && spi_master_select); endsequence
  sequence s_slave; s_run ##0 $past(spi_enable && !spi_master_select); endsequence
  sequence s_jtag; s_run ##0 $past(jtag_port_enable); endsequence
  a_clock_out_pin: assert property (
    $past(clock_out_fuse) |-> portb_pin_oe[1] && portb_pin_out[1] == $past(divided_sysclk_out))
    else $error("divided clock missing on b1");
  a_slave_inputs: assert property (
    s_slave |-> (portb_pin_oe & 8'hB0) == 8'h00) else $error("slave pins not inputs");
  a_master_miso: assert property (
    s_master |-> !portb_pin_oe[6]) else $error("master input pin driven");
  a_master_mosi: assert property (
    s_master ##0 portb_pin_oe[5] |-> portb_pin_out[5] == $past(spi_master_data_out))
    else $error("master output wrong on b5");
  a_compare_a_b3: assert property (
    s_run ##0 $past(timer0_compare_a_enable) ##0 portb_pin_oe[3]
      |-> portb_pin_out[3] == $past(timer0_compare_a_out)) else $error("compare value wrong on b3");
  a_jtag_dirs: assert property (
    s_jtag |-> portc_pin_oe[4] == $past(tap_instr_shift_state || tap_data_shift_state)
      && (portc_pin_oe & 8'h2C) == 8'h00) else $error("jtag pin direction wrong");
  a_tdo_value: assert property (
    s_jtag ##0 portc_pin_oe[4] |-> portc_pin_out[4] == $past(tap_data_out))
    else $error("test data out wrong on c4");
  a_pullup_input: assert property (
    (portb_pullup & portb_pin_oe) == 8'h00) else $error("pull-up on a driven pin");
endmodule // port_bc_monitor
bind port_bc_override port_bc_monitor u_mon (.aclk, .aresetn, .clock_out_fuse,
  .divided_sysclk_out, .spi_enable, .spi_master_select, .spi_master_data_out,
  .timer0_compare_a_out, .timer0_compare_a_enable, .jtag_port_enable, .tap_instr_shift_state,
  .tap_data_shift_state, .tap_data_out, .portb_pin_out, .portb_pin_oe, .portb_pullup,
  .portc_pin_out, .portc_pin_oe);

// ===== test/port_bc_override_tb.sv
`timescale 1ns/10ps
module port_bc_override_tb;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0, ext_b = 0, ext_c = 0;
  logic [31:0] wdata = 0, lf = 32'h0001_1282;
  logic [18:0] per = 19'h0_0003;
  logic [7:0] rg [0:6];
  wire awready, wready, bvalid, arready, rvalid, t0c, t1c;
  wire [8:0] pio;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] pin_b, pin_c, bo, boe, bpu, co, coe, cpu, pcb, pcc;
  int n_errors = 0, checks_done = 0, cyc = 0;
  port_bc_override DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .clock_out_fuse(per[0]), .divided_sysclk_out(per[1]),
    .spi_enable(per[2]), .spi_master_select(per[3]), .spi_sck_out(per[4]),
    .spi_slave_data_out(per[5]), .spi_master_data_out(per[6]), .spi_sck_in(pio[8]),
    .spi_master_data_in(pio[7]), .spi_slave_data_in(pio[6]), .spi_slave_select_n(pio[5]),
    .timer0_compare_a_out(per[7]), .timer0_compare_a_enable(per[8]),
    .timer0_compare_b_out(per[9]), .timer0_compare_b_enable(per[10]),
    .timer0_count_input(t0c), .timer1_count_input(t1c), .async_timer2_select(per[11]),
    .ext_clock_select(per[12]), .usart0_sync_mode(per[13]), .usart0_clock_out(per[14]),
    .usart0_sync_clock(pio[3]), .jtag_port_enable(per[15]), .tap_instr_shift_state(per[16]),
    .tap_data_shift_state(per[17]), .tap_data_out(per[18]), .tap_data_in(pio[2]),
    .tap_mode_in(pio[1]), .tap_clock_in(pio[0]), .ext_irq2_input(pio[4]),
    .pin_change_b(pcb), .pin_change_c(pcc),
    .portb_pin_in(pin_b), .portb_pin_out(bo), .portb_pin_oe(boe), .portb_pullup(bpu),
    .portc_pin_in(pin_c), .portc_pin_out(co), .portc_pin_oe(coe), .portc_pullup(cpu));
  pin_world u_pb (.pin_out(bo), .pin_oe(boe), .ext(ext_b), .pin_in(pin_b));
  pin_world u_pc (.pin_out(co), .pin_oe(coe), .ext(ext_c), .pin_in(pin_c));
  ////////////////////////////////////////////////////////////////////////
  // 125 MHz clock, and a cycle ceiling well above the planned run
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim;
    if (n_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [47:0] s, input logic [47:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // register write; an accepted one lands in the model
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    check(bresp, er);
    if (er == 2'h0) rg[a[4:2]] = d[7:0] & (a == 8'h18 ? 8'h0F : 8'hFF);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    check({rresp, rdata}, {er, e});
  endtask
  // expected pin controls for the peripheral state p and the model registers
  function automatic logic [47:0] exp_pins(input logic [18:0] p);
    logic [7:0] bd = rg[1];
    logic [7:0] bv = rg[0];
    logic [7:0] cd = rg[3];
    logic [7:0] cv = rg[2];
    logic [7:0] cp = rg[2];
    logic [7:0] np = {8{~rg[6][0]}};
    if (p[2] && p[3]) {bd[6], bv[7], bv[5]} = {1'h0, p[4], p[6]};
    if (p[2] && !p[3]) {bd[7], bd[5], bd[4], bv[6]} = {3'h0, p[5]};
    if (p[10]) bv[4] = p[9];
    if (p[8]) bv[3] = p[7];
    if (p[0]) {bd[1], bv[1]} = {1'h1, p[1]};
    if (p[13] && bd[0]) bv[0] = p[14];
    if (p[15]) {cd[5:2], cv[4], cp[5:2]} = {1'h0, p[16] | p[17], 2'h0, p[18], 4'hF};
    if (p[11]) {cd[6], cp[6]} = 2'h0;
    if (p[11] && p[12]) {cd[7], cp[7]} = 2'h0;
    return {bd, bv & bd, ~bd & rg[0] & np, cd, cv & cd, ~cd & cp & np};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // main sequence: reset, register map, random overrides, then input paths
  initial begin
    for (int i = 0; i < 7; i++) rg[i] = 8'h00;
    repeat (5) @(posedge aclk);
    check({boe[1], bo[1], coe, cpu}, 18'h3_0000);
    {aresetn, per} <= {1'h1, 19'h0_0000};
    for (int i = 0; i < 7; i++) rd(8'(i * 4), 0, 2'h0);
    rd(8'h20, 0, 2'h2);
    wr(8'h22, 32'h0000_00FF, 2'h2);
    repeat (6) begin
      for (int i = 0; i < 7; i++) begin
        lf = nx(lf);
        wr(8'(i * 4), lf, 2'h0);
        rd(8'(i * 4), {24'h00_0000, rg[i]}, 2'h0);
      end
      repeat (300) begin
        @(posedge aclk);
        lf = nx(lf);
        per <= lf[18:0];
        @(posedge aclk);
        #1;
        check({boe, bo & boe, bpu, coe, co & coe, cpu}, exp_pins(per));
      end
    end
    wr(8'h04, 0, 2'h0);
    wr(8'h0C, 0, 2'h0);
    wr(8'h18, 32'h0000_0006, 2'h0);
    per <= 19'h0_A004;
    repeat (8) begin
      lf = nx(lf);
      {ext_b, ext_c} <= lf[15:0];
      repeat (5) @(posedge aclk);
      #1;
      check({pcb, pcc, t1c, t0c, pio}, {ext_b & rg[4], ext_c & rg[5], ext_b[1:0],
             ext_b[7:4], ext_b[2], ext_b[0], ext_c[5], ext_c[3:2]});
      rd(8'h1C, {16'h0000, ext_c, ext_b}, 2'h0);
    end
    end_sim();
  end
endmodule // port_bc_override_tb
